// >>> acp_pointer_ctrl.sv
// Accumulator pointer and pointer control system registers
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module acp_pointer_ctrl
  import acp_pkg::*;
(
  input  wire logic            sys_clk,
  input  wire logic            rst,
  input  wire acp_sysreg_req_s req,
  input  wire logic            alu_op_done,
  output logic [7:0]           rdata,
  output logic                 rhit,
  output logic [3:0]           active_acc_pointer,
  output acp_control_s         acc_pointer_control
);

  ////////////////////////////////////////////////////////////////////////////
  // Step arithmetic: only bits under the wrap mask move
  function automatic logic [3:0] acp_step(input logic [3:0] ptr,
                                          input logic [2:0] modulus,
                                          input logic       down);
    logic [3:0] mask;
    logic [3:0] moved;
    mask = ACP_WRAP_16;
    unique case (modulus)
      ACP_MOD_2: mask = ACP_WRAP_2;
      ACP_MOD_4: mask = ACP_WRAP_4;
      ACP_MOD_8: mask = ACP_WRAP_8;
      default:   mask = ACP_WRAP_16;
    endcase
    moved = down ? (ptr - ACP_ONE) : (ptr + ACP_ONE);
    return (ptr & ~mask) | (moved & mask);
  endfunction

  // Address match, shared by the write and read decode
  function automatic logic acp_addr_hit(input acp_sysreg_req_s r,
                                        input logic [3:0]      idx);
    return (r.module_sel == ACP_MODULE_SYS) && (r.index == idx);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic       wr_pointer;
  logic       wr_control;
  logic       step_on;
  logic       zero_req;
  logic [3:0] next_pointer;

  assign wr_pointer = req.wr && acp_addr_hit(req, ACP_IDX_POINTER);
  assign wr_control = req.wr && acp_addr_hit(req, ACP_IDX_CONTROL);
  assign step_on    = (acc_pointer_control.autostep_modulus != ACP_MOD_OFF);
  assign zero_req   = wr_control && req.wdata[ACP_BIT_ZERO];

  always_comb begin
    next_pointer = active_acc_pointer;
    if (zero_req) begin
      next_pointer = ACP_POINTER_RESET[3:0];
    end else if (step_on && (alu_op_done || wr_pointer)) begin
      // Stepping takes precedence over a transfer into the pointer
      next_pointer = acp_step(active_acc_pointer,
                              acc_pointer_control.autostep_modulus,
                              acc_pointer_control.step_direction_select);
    end else if (wr_pointer) begin
      next_pointer = req.wdata[3:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      active_acc_pointer <= ACP_POINTER_RESET[3:0];
    end else begin
      active_acc_pointer <= next_pointer;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clear bit is an action, never stored, so it reads back zero
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      acc_pointer_control <= ACP_CONTROL_RESET;
    end else if (wr_control) begin
      acc_pointer_control.autostep_modulus      <= req.wdata[2:0];
      acc_pointer_control.step_direction_select <= req.wdata[ACP_BIT_DIRECTION];
      acc_pointer_control.unused                <= 3'h0;
      acc_pointer_control.pointer_zero_strobe   <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data is combinational from registers, same cycle as rd
  always_comb begin
    rdata = 8'h00;
    rhit  = 1'b0;
    if (req.rd && acp_addr_hit(req, ACP_IDX_POINTER)) begin
      rdata = {4'h0, active_acc_pointer} & ACP_POINTER_MASK;
      rhit  = 1'b1;
    end else if (req.rd && acp_addr_hit(req, ACP_IDX_CONTROL)) begin
      rdata = acc_pointer_control & ACP_CONTROL_MASK & ~8'h80;
      rhit  = 1'b1;
    end
  end

endmodule

// >>> acp_pkg.sv
// Package: addresses, fields and types of the accumulator pointer control block
package acp_pkg;

  localparam logic [3:0] ACP_MODULE_LO     = 4'h8;
  localparam logic [3:0] ACP_MODULE_HI     = 4'hf;
  localparam logic [3:0] ACP_MODULE_SYS    = 4'h8;
  localparam logic [3:0] ACP_IDX_POINTER   = 4'h0;
  localparam logic [3:0] ACP_IDX_CONTROL   = 4'h1;

  localparam logic [7:0] ACP_POINTER_RESET = 8'h00;
  localparam logic [7:0] ACP_CONTROL_RESET = 8'h00;
  localparam logic [7:0] ACP_POINTER_MASK  = 8'h0f;
  localparam logic [7:0] ACP_CONTROL_MASK  = 8'hc7;

  localparam int ACP_BIT_DIRECTION = 6;
  localparam int ACP_BIT_ZERO      = 7;

  localparam logic [2:0] ACP_MOD_OFF = 3'h0;
  localparam logic [2:0] ACP_MOD_2   = 3'h1;
  localparam logic [2:0] ACP_MOD_4   = 3'h2;
  localparam logic [2:0] ACP_MOD_8   = 3'h3;

  localparam logic [3:0] ACP_WRAP_2  = 4'h1;
  localparam logic [3:0] ACP_WRAP_4  = 4'h3;
  localparam logic [3:0] ACP_WRAP_8  = 4'h7;
  localparam logic [3:0] ACP_WRAP_16 = 4'hf;
  localparam logic [3:0] ACP_ONE     = 4'h1;

  // System register access from the instruction execution logic
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] module_sel;
    logic [3:0] index;
    logic [7:0] wdata;
  } acp_sysreg_req_s;

  // Control register fields, bits 5..3 always zero
  typedef struct packed {
    logic       pointer_zero_strobe;
    logic       step_direction_select;
    logic [2:0] unused;
    logic [2:0] autostep_modulus;
  } acp_control_s;

endpackage

// >>> acp_core_model.sv
// Core model: one ALU completion pulse per request
`timescale 1ns/1ps
module acp_core_model (
  input  wire logic sys_clk,
  input  wire logic go,
  output logic      alu_op_done
);
  initial alu_op_done = 1'b0;
  // Registered like the real execute stage
  always @(posedge sys_clk) alu_op_done <= #1 go;
endmodule

// >>> acp_properties.sv
// Checker of the pointer control block
`timescale 1ns/1ps
module acp_properties
  import acp_pkg::*;
(
  input wire logic            sys_clk,
  input wire logic            rst,
  input wire acp_sysreg_req_s req,
  input wire logic            alu_op_done,
  input wire logic [7:0]      rdata,
  input wire logic            rhit,
  input wire logic [3:0]      active_acc_pointer,
  input wire acp_control_s    acc_pointer_control
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire       m8 = req.module_sel == 4'h8;
  wire       wc = req.wr && m8 && req.index == 4'h1;
  wire       st = (alu_op_done || req.wr && m8 && req.index == 4'h0) && !wc;
  wire [2:0] md = acc_pointer_control.autostep_modulus;
  wire       dn = acc_pointer_control.step_direction_select;
  wire [3:0] p  = active_acc_pointer;
  AST_RESET: assert property (disable iff (1'b0) rst |=> p == 4'h0 &&
    acc_pointer_control == 8'h00) else $error("reset");
  AST_RSVD: assert property ({acc_pointer_control[7], acc_pointer_control[5:3]} == 4'h0)
    else $error("rsvd");
  AST_ZERO: assert property (wc && req.wdata[7] |=> p == 4'h0) else $error("zero");
  AST_LOAD: assert property (st && !alu_op_done && md == 3'h0 |=>
    {4'h0, p} == ($past(req.wdata) & 8'h0f)) else $error("load");
  AST_OFF: assert property (alu_op_done && md == 3'h0 && !req.wr |=> $stable(p))
    else $error("off");
  AST_M2: assert property (st && md == 3'h1 |=> p == ($past(p) ^ 4'h1)) else $error("m2");
  AST_M4D: assert property (st && md == 3'h2 && dn |=>
    p == (($past(p) & 4'hc) | (($past(p) - 4'h1) & 4'h3))) else $error("m4");
  AST_M16: assert property (st && md == 3'h4 && !dn |=> p == $past(p) + 4'h1)
    else $error("m16");
  AST_RES: assert property (st && md > 3'h4 && dn |=> p == $past(p) - 4'h1)
    else $error("res");
  AST_READ: assert property (req.rd && m8 && req.index == 4'h0 |-> rhit &&
    rdata == {4'h0, p}) else $error("read");
  AST_MISS: assert property (!m8 |-> !rhit && rdata == 8'h00) else $error("miss");
  C_STEP: cover property (alu_op_done && md != 3'h0);
  C_CLR: cover property (wc && req.wdata[7]);
  C_RD: cover property (req.rd && rhit);
endmodule
bind acp_pointer_ctrl acp_properties u_chk (.*);

// >>> acp_pointer_ctrl_tb.sv
// Testbench of the pointer control block
`timescale 1ns/1ps
module acp_pointer_ctrl_tb
  import acp_pkg::*;
;
  logic sys_clk = 0, rst = 1, go = 0, alu_op_done, rhit;
  acp_sysreg_req_s req = '0;
  logic [7:0] rdata;
  logic [3:0] p;
  acp_control_s c;
  int err_count = 0, checks_done = 0;
  // Rows: control, start pointer, pointer after one operation
  logic [15:0] rows [9] = '{16'h0055, 16'h0154, 16'h4203, 16'h0370, 16'h04f0,
    16'h450f, 16'h0634, 16'h4710, 16'h4055};
  acp_pointer_ctrl dut (.sys_clk(sys_clk), .rst(rst), .req(req), .alu_op_done(alu_op_done),
    .rdata(rdata), .rhit(rhit), .active_acc_pointer(p), .acc_pointer_control(c));
  acp_core_model core (.sys_clk(sys_clk), .go(go), .alu_op_done(alu_op_done));
  initial forever #10 sys_clk = ~sys_clk;
  task chk(string n, logic [7:0] e, logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  task end_of_test;
    $display("errors %0d checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task wr(logic [3:0] i, logic [7:0] d);
    @(posedge sys_clk) #1 req = '{1'b1, 1'b0, 4'h8, i, d};
    @(posedge sys_clk) #1 req = '0;
  endtask
  task rd(logic [3:0] m, logic [3:0] i, logic [7:0] e, logic h);
    @(posedge sys_clk) #1 req = '{1'b0, 1'b1, m, i, 8'h00};
    #5 chk("rdata", e, rdata);
    chk("rhit", {7'h00, h}, {7'h00, rhit});
    @(posedge sys_clk) #1 req = '0;
  endtask
  task op;
    @(posedge sys_clk) #1 go = 1;
    @(posedge sys_clk) #1 go = 0;
    @(posedge sys_clk) #1;
  endtask
  initial #200000 begin
    err_count++;
    end_of_test;
  end
  initial begin
    repeat (5) @(posedge sys_clk);
    #1 rst = 0;
    chk("rst_p", 8'h00, {4'h0, p});
    chk("rst_c", 8'h00, c);
    foreach (rows[k]) begin
      wr(4'h1, 8'h00);
      wr(4'h0, {4'h0, rows[k][7:4]});
      wr(4'h1, rows[k][15:8]);
      op;
      chk("step", {4'h0, rows[k][3:0]}, {4'h0, p});
      rd(4'h8, 4'h1, rows[k][15:8] & 8'hc7, 1'b1);
    end
    wr(4'h1, 8'h00);
    wr(4'h0, 8'hfa);
    rd(4'h8, 4'h0, 8'h0a, 1'b1);
    rd(4'h9, 4'h0, 8'h00, 1'b0);
    wr(4'h1, 8'h42);
    wr(4'h0, 8'h0c);
    chk("load_step", 8'h09, {4'h0, p});
    wr(4'h1, 8'hff);
    chk("clr", 8'h00, {4'h0, p});
    rd(4'h8, 4'h1, 8'h47, 1'b1);
    wr(4'h1, 8'h00);
    wr(4'h0, 8'h04);
    wr(4'h1, 8'h01);
    fork
      op;
      begin
        @(posedge sys_clk);
        wr(4'h0, 8'h0b);
      end
    join
    chk("one_step", 8'h05, {4'h0, p});
    @(posedge sys_clk) #1 rst = 1;
    @(posedge sys_clk) #1 rst = 0;
    chk("rst2", 8'h00, c);
    chk("rst2_p", 8'h00, {4'h0, p});
    end_of_test;
  end
endmodule
